//--- rtl/adsc_control.v
`timescale 1ns/1ns
`include "adsc_map.vh"

module adsc_control
(
	input wire clk,
	input wire reset,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr_en,
	input wire rd_en,
	output wire [7:0] rdata,
	input wire halt_mode,
	input wire cmp_above,
	output wire converter_power_on,
	output wire sample_en,
	output wire [7:0] dac_code,
	output wire [2:0] channel_select,
	output wire [7:0] analog_switch_en,
	output wire irq
);

	localparam [1:0] ST_OFF = 2'd0;
	localparam [1:0] ST_STAB = 2'd1;
	localparam [1:0] ST_CONV = 2'd2;

	localparam integer CONV_LAST_I = `ADSC_CONV_CYC - 1;
	localparam integer SAMPLE_END_I = `ADSC_SAMPLE_CYC - 1;
	localparam integer TRIAL_LAST_I = `ADSC_TRIAL_CYC - 1;
	localparam integer STAB_LAST_I = `ADSC_STAB_CYC - 1;
	localparam [5:0] CYC_LAST = CONV_LAST_I[5:0];
	localparam [5:0] CYC_SAMPLE_END = SAMPLE_END_I[5:0];
	localparam [1:0] TRIAL_LAST = TRIAL_LAST_I[1:0];
	localparam [11:0] STAB_LAST = STAB_LAST_I[11:0];

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [5:0] cyc_q;
	reg [1:0] trial_q;
	reg [11:0] stab_q;

	reg pwr_q;
	reg [2:0] chan_q;
	reg done_q;
	reg [7:0] result_q;
	reg [7:0] rdata_q;
	reg [`ADSC_IRQ_N-1:0] irq_stat_q;
	reg [`ADSC_IRQ_N-1:0] irq_en_q;
	reg irq_q;

	reg [7:0] dac_q;
	reg [7:0] mask_q;
	reg sample_q;
	reg power_q;
	reg [7:0] switch_q;

	wire csr_wr;
	wire res_rd;
	wire clr_wr;
	wire en_wr;
	wire in_conv;
	wire sampling;
	wire decide;
	wire [7:0] kept;
	wire conv_end;
	wire done_evt;
	wire stab_end;
	wire [`ADSC_IRQ_N-1:0] irq_evt;
	reg [7:0] read_mux;

	assign csr_wr = wr_en && (addr == `ADSC_OFS_CSR);
	assign res_rd = rd_en && (addr == `ADSC_OFS_RESULT);
	assign clr_wr = wr_en && (addr == `ADSC_OFS_IRQ_CLR);
	assign en_wr = wr_en && (addr == `ADSC_OFS_IRQ_EN);

	assign in_conv = (state_q == ST_CONV);
	assign sampling = in_conv && (cyc_q <= CYC_SAMPLE_END);
	assign decide = in_conv && !sampling && (trial_q == TRIAL_LAST);

	// comparator says input at or above trial level: keep the trial bit
	assign kept = cmp_above ? dac_q : (dac_q & ~mask_q);

	assign conv_end = decide && (cyc_q == CYC_LAST);
	// a control write aborts the finishing conversion too
	assign done_evt = conv_end && !csr_wr;
	assign stab_end = (state_q == ST_STAB) && (stab_q == STAB_LAST);

	assign irq_evt[`ADSC_IRQ_STABLE] = stab_end && !halt_mode;
	assign irq_evt[`ADSC_IRQ_OVERRUN] = done_evt && done_q && !res_rd;
	assign irq_evt[`ADSC_IRQ_ABORT] = csr_wr && in_conv;

	// sequencer
	always @*
	begin
		state_d = state_q;
		if (halt_mode)
		begin
			state_d = ST_OFF;
		end
		else
		begin
			case (state_q)
				ST_OFF:
				begin
					// power-on or wake from halt restarts stabilisation
					if (pwr_q)
					begin
						state_d = ST_STAB;
					end
				end
				ST_STAB:
				begin
					if (!pwr_q)
					begin
						state_d = ST_OFF;
					end
					else if (stab_end)
					begin
						state_d = ST_CONV;
					end
				end
				ST_CONV:
				begin
					if (!pwr_q)
					begin
						state_d = ST_OFF;
					end
				end
				default:
				begin
					state_d = ST_OFF;
				end
			endcase
		end
	end

	// wait mode has no input here: the converter simply keeps running
	always @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= ST_OFF;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// stabilisation timer
	always @(posedge clk)
	begin
		if (reset)
		begin
			stab_q <= 12'h000;
		end
		else if (state_q != ST_STAB)
		begin
			stab_q <= 12'h000;
		end
		else if (!stab_end)
		begin
			stab_q <= stab_q + 12'h001;
		end
	end

	// conversion cycle counter, free running while converting
	always @(posedge clk)
	begin
		if (reset)
		begin
			cyc_q <= 6'h00;
			trial_q <= 2'h0;
		end
		else if (!in_conv || csr_wr)
		begin
			cyc_q <= 6'h00;
			trial_q <= 2'h0;
		end
		else
		begin
			cyc_q <= cyc_q + 6'h01;
			if (!sampling)
			begin
				trial_q <= trial_q + 2'h1;
			end
		end
	end

	// successive approximation register
	always @(posedge clk)
	begin
		if (reset)
		begin
			dac_q <= 8'h00;
			mask_q <= 8'h00;
		end
		else if (!in_conv || csr_wr || conv_end)
		begin
			dac_q <= 8'h00;
			mask_q <= 8'h00;
		end
		else if (in_conv && cyc_q == CYC_SAMPLE_END)
		begin
			dac_q <= 8'h80;
			mask_q <= 8'h80;
		end
		else if (decide)
		begin
			// all ones gives ffh, all zeros gives 00h, nothing beyond
			dac_q <= kept | (mask_q >> 1);
			mask_q <= mask_q >> 1;
		end
	end

	// result register and completion flag
	always @(posedge clk)
	begin
		if (reset)
		begin
			result_q <= `ADSC_RST_BYTE;
			done_q <= 1'b0;
		end
		else
		begin
			if (done_evt)
			begin
				result_q <= kept;
				done_q <= 1'b1;
			end
			else if (csr_wr || res_rd)
			begin
				done_q <= 1'b0;
			end
		end
	end

	// control fields
	always @(posedge clk)
	begin
		if (reset)
		begin
			pwr_q <= 1'b0;
			chan_q <= 3'h0;
		end
		else if (csr_wr)
		begin
			pwr_q <= wdata[`ADSC_BIT_PWR];
			chan_q <= wdata[`ADSC_CHAN_MSB:0];
		end
	end

	// analog side outputs
	always @(posedge clk)
	begin
		if (reset)
		begin
			power_q <= 1'b0;
			sample_q <= 1'b0;
		end
		else
		begin
			power_q <= pwr_q && !halt_mode;
			sample_q <= (state_d == ST_CONV) && (conv_end || cyc_q < CYC_SAMPLE_END || !in_conv || csr_wr);
		end
	end

	// one input switch per channel
	genvar ch;
	generate
		for (ch = 0; ch < 8; ch = ch + 1)
		begin : g_switch
			localparam integer CH_I = ch;
			always @(posedge clk)
			begin
				if (reset)
				begin
					switch_q[ch] <= 1'b0;
				end
				else
				begin
					switch_q[ch] <= power_q && (chan_q == CH_I[2:0]);
				end
			end
		end
	endgenerate

	// sticky interrupt status; set wins over clear
	genvar ib;
	generate
		for (ib = 0; ib < `ADSC_IRQ_N; ib = ib + 1)
		begin : g_irq
			always @(posedge clk)
			begin
				if (reset)
				begin
					irq_stat_q[ib] <= 1'b0;
				end
				else if (irq_evt[ib])
				begin
					irq_stat_q[ib] <= 1'b1;
				end
				else if (clr_wr && wdata[ib])
				begin
					irq_stat_q[ib] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge clk)
	begin
		if (reset)
		begin
			irq_en_q <= {`ADSC_IRQ_N{1'b0}};
			irq_q <= 1'b0;
		end
		else
		begin
			if (en_wr)
			begin
				irq_en_q <= wdata[`ADSC_IRQ_N-1:0];
			end
			// completion is deliberately not an interrupt source
			irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

	// register read, data one cycle after the strobe
	always @*
	begin
		read_mux = 8'h00;
		case (addr)
			`ADSC_OFS_RESULT:
			begin
				read_mux = result_q;
			end
			`ADSC_OFS_CSR:
			begin
				read_mux[`ADSC_BIT_DONE] = done_q;
				read_mux[`ADSC_BIT_PWR] = pwr_q;
				read_mux[`ADSC_CHAN_MSB:0] = chan_q;
			end
			`ADSC_OFS_IRQ_STAT:
			begin
				read_mux[`ADSC_IRQ_N-1:0] = irq_stat_q;
			end
			`ADSC_OFS_IRQ_EN:
			begin
				read_mux[`ADSC_IRQ_N-1:0] = irq_en_q;
			end
			`ADSC_OFS_STATE:
			begin
				read_mux[1:0] = state_q;
			end
			default:
			begin
				read_mux = 8'h00;
			end
		endcase
	end

	always @(posedge clk)
	begin
		if (reset)
		begin
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= rd_en ? read_mux : 8'h00;
		end
	end

	assign rdata = rdata_q;
	assign converter_power_on = power_q;
	assign sample_en = sample_q;
	assign dac_code = dac_q;
	assign channel_select = chan_q;
	assign analog_switch_en = switch_q;
	assign irq = irq_q;

endmodule // adsc_control

//--- shared/adsc_map.vh
`ifndef ADSC_MAP_VH
`define ADSC_MAP_VH
// register offsets
`define ADSC_OFS_RESULT 8'h70
`define ADSC_OFS_CSR 8'h71
`define ADSC_OFS_IRQ_STAT 8'h72
`define ADSC_OFS_IRQ_CLR 8'h73
`define ADSC_OFS_IRQ_EN 8'h74
`define ADSC_OFS_STATE 8'h75
// control/status fields
`define ADSC_BIT_DONE 7
`define ADSC_BIT_PWR 5
`define ADSC_CHAN_MSB 2
`define ADSC_RST_BYTE 8'h00
// interrupt status bits
`define ADSC_IRQ_N 3
`define ADSC_IRQ_STABLE 0
`define ADSC_IRQ_OVERRUN 1
`define ADSC_IRQ_ABORT 2
// timing
`define ADSC_CLK_NS 10
`define ADSC_CONV_CYC 64
`define ADSC_SAMPLE_HALF_CYC 63
`define ADSC_SAMPLE_CYC ((`ADSC_SAMPLE_HALF_CYC + 1) / 2)
`define ADSC_BITS 8
`define ADSC_TRIAL_CYC ((`ADSC_CONV_CYC - `ADSC_SAMPLE_CYC) / `ADSC_BITS)
`define ADSC_STAB_NS 30000
`define ADSC_STAB_CYC ((`ADSC_STAB_NS + `ADSC_CLK_NS - 1) / `ADSC_CLK_NS)
`endif

//--- testbench/adsc_assertions.sv
`timescale 1ns/1ns
module adsc_assertions
(
	input wire clk,
	input wire reset,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] rdata,
	input wire halt_mode,
	input wire converter_power_on,
	input wire sample_en,
	input wire [7:0] dac_code,
	input wire [2:0] channel_select,
	input wire [7:0] analog_switch_en
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	wire csr_wr = wr_en && addr == 8'h71;
	AST_RD_IDLE: assert property (!rd_en |=> rdata == 8'h00) else $error("rdata not idle");
	AST_CSR_ZERO: assert property (rd_en && addr == 8'h71 |=> rdata[6] == 1'b0 && rdata[4:3] == 2'b00)
		else $error("reserved bits set");
	// a normal end of sampling shows the first trial code
	AST_SAMPLE_LEN: assert property ($fell(sample_en) && dac_code == 8'h80 |-> $past(sample_en, 32))
		else $error("sampling length wrong");
	// switches follow the channel field one cycle late
	AST_SWITCH: assert property (analog_switch_en != 8'h00 |-> analog_switch_en == 8'h01 << $past(channel_select))
		else $error("switch not one-hot on channel");
	AST_POWER_ON: assert property (csr_wr && wdata[5] && !halt_mode ##1 !halt_mode |=> converter_power_on)
		else $error("power on missing");
	AST_POWER_OFF: assert property (!converter_power_on [*2] |-> !sample_en && analog_switch_en == 8'h00)
		else $error("activity while off");
	AST_HALT: assert property (halt_mode [*2] |-> !converter_power_on) else $error("running in halt");
	AST_ABORT: assert property (csr_wr && wdata[5] && !halt_mode && converter_power_on && dac_code != 8'h00
		|=> sample_en && dac_code == 8'h00) else $error("write did not restart");
	cover property ($fell(sample_en));
	cover property (csr_wr && dac_code != 8'h00);
	cover property (halt_mode [*2]);
endmodule // adsc_assertions

bind adsc_control adsc_assertions u_chk (.clk, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata, .halt_mode,
	.converter_power_on, .sample_en, .dac_code, .channel_select, .analog_switch_en);

//--- testbench/adsc_analog.sv
`timescale 1ns/1ns
module adsc_analog
(
	input wire clk,
	input wire [63:0] levels,
	input wire [2:0] channel_select,
	input wire [7:0] analog_switch_en,
	input wire sample_en,
	input wire [7:0] dac_code,
	output wire cmp_above
);
	reg [7:0] held_q = 8'h00;
	// track and hold follows channel_select while sampling and any switch is closed
	always @(posedge clk)
	begin
		if (sample_en && analog_switch_en != 8'h00)
			held_q <= levels[channel_select * 8 +: 8];
	end
	// ffh is the high reference, 00h the low one
	assign cmp_above = held_q >= dac_code;
endmodule // adsc_analog

//--- testbench/adsc_control_bench.sv
`timescale 1ns/1ns
`include "adsc_map.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module adsc_control_bench;
	reg clk = 0, reset = 1, wr_en = 0, rd_en = 0, halt_mode = 0, rd_d = 0;
	reg [7:0] addr = 8'h00, wdata = 8'h00;
	reg [63:0] levels = 64'h0;
	reg [16:0] seed = 17'd77179;
	reg [15:0] notes[$];
	reg [15:0] n;
	wire [7:0] rdata, dac_code, analog_switch_en;
	wire [2:0] channel_select;
	wire cmp_above, converter_power_on, sample_en, irq;
	int fail_count = 0, checked = 0, cyc = 0, i;
	adsc_control DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .halt_mode(halt_mode), .cmp_above(cmp_above), .converter_power_on(converter_power_on),
		.sample_en(sample_en), .dac_code(dac_code), .channel_select(channel_select),
		.analog_switch_en(analog_switch_en), .irq(irq));
	adsc_analog u_src (.clk(clk), .levels(levels), .channel_select(channel_select),
		.analog_switch_en(analog_switch_en), .sample_en(sample_en), .dac_code(dac_code), .cmp_above(cmp_above));
	initial forever #5 clk = ~clk;
	function [16:0] lfsr(input [16:0] s);
		lfsr = {s[15:0], s[16] ^ s[13]};
	endfunction
	task tick(input int k);
		wr_en <= 0;
		rd_en <= 0;
		repeat (k) @(posedge clk);
	endtask
	// one bus cycle; a read notes its masked expectation
	task bus(input w, input r, input [7:0] a, input [7:0] d, input [7:0] m, input [7:0] e);
		wr_en <= w;
		rd_en <= r;
		addr <= a;
		wdata <= d;
		if (r)
			notes.push_back({m, e & m});
		@(posedge clk);
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		rd_d <= rd_en;
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			fail_count++;
			give_verdict;
		end
		if (rd_d)
		begin
			n = notes.pop_front();
			`CHK("rdata", n[7:0], rdata & n[15:8])
		end
	end
	initial
	begin
		tick(8);
		reset <= 0;
		for (i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			levels[i * 8 +: 8] <= seed[7:0];
		end
		levels[15:0] <= 16'h00ff;
		bus(1, 0, 8'h70, 8'h55, 0, 0);
		bus(0, 1, 8'h70, 0, 8'hff, 8'h00);
		bus(0, 1, 8'h71, 0, 8'hff, 8'h00);
		bus(0, 1, 8'h7f, 0, 8'hff, 8'h00);
		bus(1, 0, 8'h74, 8'h07, 0, 0);
		bus(1, 0, 8'h71, 8'h23, 0, 0);
		tick(`ADSC_STAB_CYC + 4);
		`CHK("irq", 1'b1, irq)
		bus(0, 1, 8'h72, 0, 8'h01, 8'h01);
		bus(1, 0, 8'h73, 8'h07, 0, 0);
		bus(1, 0, 8'h74, 8'h01, 0, 0);
		tick(3);
		`CHK("irq", 1'b0, irq)
		for (i = 0; i < 8; i++)
		begin
			bus(1, 0, 8'h71, 8'h20 | i[7:0], 0, 0);
			tick(`ADSC_CONV_CYC + 2);
			bus(0, 1, 8'h71, 0, 8'hff, 8'ha0 | i[7:0]);
			bus(0, 1, 8'h70, 0, 8'hff, levels[i * 8 +: 8]);
			bus(0, 1, 8'h71, 0, 8'hff, 8'h20 | i[7:0]);
			tick(`ADSC_CONV_CYC);
			bus(0, 1, 8'h71, 0, 8'h80, 8'h80);
			tick(40);
			bus(1, 0, 8'h71, 8'h20 | i[7:0], 0, 0);
			bus(0, 1, 8'h71, 0, 8'hff, 8'h20 | i[7:0]);
			`CHK("irq", 1'b0, irq)
		end
		tick(40);
		halt_mode <= 1;
		tick(4);
		`CHK("power", 1'b0, converter_power_on)
		halt_mode <= 0;
		tick(40);
		bus(0, 1, 8'h75, 0, 8'h03, 8'h01);
		bus(1, 0, 8'h71, 8'h17, 0, 0);
		tick(4);
		`CHK("power", 1'b0, converter_power_on)
		bus(0, 1, 8'h71, 0, 8'hff, 8'h07);
		tick(3);
		give_verdict;
	end
endmodule // adsc_control_bench
